// ---- hdl/load_unit_pkg.sv ----
package load_unit_pkg;

  localparam int XLEN         = 64;
  localparam int DISP_W       = 16;
  localparam int HIGH_SHIFT   = 16;
  localparam int REG_IDX_W    = 5;
  localparam int CHAR_W       = 8;
  localparam logic [REG_IDX_W-1:0] ZERO_REG = 5'h1F;

  // Big-endian lane inversion per access size
  localparam logic [2:0] XOR_QUAD = 3'h0;
  localparam logic [2:0] XOR_LONG = 3'h4;
  localparam logic [2:0] XOR_WORD = 3'h6;
  localparam logic [2:0] XOR_BYTE = 3'h7;

  // Natural alignment masks on the low address bits
  localparam logic [2:0] ALIGN_QUAD = 3'h7;
  localparam logic [2:0] ALIGN_LONG = 3'h3;
  localparam logic [2:0] ALIGN_WORD = 3'h1;
  localparam logic [2:0] ALIGN_BYTE = 3'h0;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFFSET        = 8'h00;
  localparam logic [7:0] FEATURE_OFFSET     = 8'h04;
  localparam logic [7:0] STATUS_OFFSET      = 8'h08;
  localparam logic [7:0] FAULT_VA_LO_OFFSET = 8'h0C;
  localparam logic [7:0] FAULT_VA_HI_OFFSET = 8'h10;
  localparam int CTRL_BIG_ENDIAN_BIT  = 0;
  localparam int FEATURE_WORD_BYTE_BIT = 0;
  localparam int STATUS_BUSY_BIT      = 8;
  localparam logic CTRL_BIG_ENDIAN_RST = 1'b0;

  // Qualifier letters
  localparam logic [7:0] CHAR_C = 8'h43;
  localparam logic [7:0] CHAR_D = 8'h44;
  localparam logic [7:0] CHAR_M = 8'h4D;
  localparam logic [7:0] CHAR_I = 8'h49;
  localparam logic [7:0] CHAR_S = 8'h53;
  localparam logic [7:0] CHAR_U = 8'h55;
  localparam logic [7:0] CHAR_V = 8'h56;

  typedef enum logic [2:0] {
    OP_ADDRESS_COMPUTE_LOAD,
    OP_ADDRESS_COMPUTE_HIGH_LOAD,
    OP_QUADWORD_LOAD,
    OP_SIGNED_LONGWORD_LOAD,
    OP_UNSIGNED_WORD_LOAD,
    OP_UNSIGNED_BYTE_LOAD,
    OP_UNALIGNED_QUADWORD_LOAD
  } load_op_type;

  typedef enum logic [1:0] {
    SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_QUAD
  } access_size_type;

  typedef enum logic [2:0] {
    FAULT_NONE, FAULT_ACCESS_VIOLATION, FAULT_ALIGNMENT, FAULT_ON_READ,
    FAULT_TRANSLATION_NOT_VALID, FAULT_EMULATE
  } fault_type;

  typedef enum logic [1:0] {
    ROUND_NORMAL, ROUND_CHOPPED, ROUND_DYNAMIC, ROUND_MINUS_INF
  } round_type;

  typedef struct packed {
    round_type rounding;
    logic      inexact_en;
    logic      completion_en;
    logic      underflow_en;
    logic      overflow_en;
  } qualifier_type;

  localparam qualifier_type QUAL_DEFAULT =
    '{ROUND_NORMAL, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    load_op_type           op;
    logic [REG_IDX_W-1:0]  dest_reg_field;
    logic [XLEN-1:0]       base_value;
    logic [DISP_W-1:0]     disp;
  } load_req_type;

  typedef struct packed {
    logic [XLEN-1:0]  endian_adjusted_addr;
    access_size_type  size;
    logic             plain_a;
    logic             evict_next_plain_a;
  } mem_req_type;

  typedef struct packed {
    logic [XLEN-1:0] data;
    fault_type       fault;
  } mem_rsp_type;

  typedef struct packed {
    logic [REG_IDX_W-1:0] dest_reg_field;
    logic [XLEN-1:0]      data;
    fault_type            fault;
    logic [XLEN-1:0]      fault_va;
  } result_type;

endpackage

// ---- hdl/integer_load_unit.sv ----
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// How it works
// - Decode letters C D M I S U V into operate variant flags.
// - No letters gives normal rounding and every enable off.
// - Address compute load writes base plus sign-extended displacement.
// - High address compute load adds displacement shifted left sixteen.
// - Both address compute loads write full sum, never fault.
// - Memory load address is base plus sign-extended displacement.
// - Big-endian inverts low bits per size; little-endian keeps them.
// - Faults report the address before inversion, low three bits cleared for unaligned quadword.
// - Quadword load writes all bits; longword is sign-extended.
// - Word and byte loads are zero-extended to full width.
// - Word or byte lands rightmost, upper bytes zero, either endian.
// - Misaligned word, longword, quadword loads raise alignment, except prefetches to register 31.
// - Sized loads fault only access, alignment, read, translation, plus emulate for word and byte without HW_WORD_BYTE.
// - Longword to register 31 prefetches; quadword prefetches evict-next.
// - Quadword to register 31 is the evict-next plain_a, no write.
// - Unaligned quadword clears low three bits, loads whole quadword.
// - Unaligned quadword never raises alignment fault.
// - Feature mask bit 0 clear when word and byte loads exist.
// - Byte-granular accesses; word and byte loads use no sparse space.
// - No partial block reads for stores; only reads are issued.
// - Memory gets full byte address and access length.
module integer_load_unit
  import load_unit_pkg::*;
#(
  parameter int QUAL_CHARS   = 4,
  parameter bit HW_WORD_BYTE = 1'b1
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       ce_in,
  input  wire logic                       hsel_in,
  input  wire logic [31:0]                haddr_in,
  input  wire logic [1:0]                 htrans_in,
  input  wire logic                       hwrite_in,
  input  wire logic [2:0]                 hsize_in,
  input  wire logic [31:0]                hwdata_in,
  input  wire logic                       hready_in,
  output logic                            hreadyout_out,
  output logic                            hresp_out,
  output logic [31:0]                     hrdata_out,
  input  wire logic [QUAL_CHARS*CHAR_W-1:0] qual_chars_in,
  output qualifier_type                   qual_out,
  input  wire logic                       req_valid_in,
  input  wire load_req_type               req_in,
  output logic                            req_ready_out,
  output logic                            mem_req_valid_out,
  output mem_req_type                     mem_req_out,
  input  wire logic                       mem_req_ready_in,
  input  wire logic                       mem_rsp_valid_in,
  input  wire mem_rsp_type                mem_rsp_in,
  output logic                            wb_valid_out,
  output logic                            fault_valid_out,
  output result_type                      result_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} state_type;

  state_type            st_reg;
  state_type            st_next;
  logic                 big_endian_reg;
  logic                 bus_wr_reg;
  logic [7:0]           bus_addr_reg;
  logic [31:0]          hrdata_reg;
  qualifier_type        qual_reg;
  mem_req_type          mem_req_reg;
  result_type           result_reg;
  logic                 wb_valid_reg;
  logic                 fault_valid_reg;
  logic [REG_IDX_W-1:0] pend_dest_reg;
  logic [XLEN-1:0]      pend_va_reg;
  access_size_type      pend_size_reg;
  logic                 pend_plain_a_reg;
  fault_type            last_fault_reg;
  logic [XLEN-1:0]      last_fault_va_reg;

  // Qualifier letter decode, one stage per character
  logic [6:0] qual_acc [0:QUAL_CHARS];
  assign qual_acc[0] = 7'h00;
  genvar gi;
  generate
    for (gi = 0; gi < QUAL_CHARS; gi++) begin : g_qual
      wire logic [7:0] ch = qual_chars_in[gi*CHAR_W +: CHAR_W];
      assign qual_acc[gi+1] = qual_acc[gi] | {ch == CHAR_C, ch == CHAR_D,
        ch == CHAR_M, ch == CHAR_I, ch == CHAR_S, ch == CHAR_U,
        ch == CHAR_V};
    end
  endgenerate

  wire logic [6:0] qual_hits = qual_acc[QUAL_CHARS];
  qualifier_type   qual_next;
  always_comb begin
    qual_next = QUAL_DEFAULT;
    if (qual_hits[5]) begin
      qual_next.rounding = ROUND_DYNAMIC;
    end else if (qual_hits[4]) begin
      qual_next.rounding = ROUND_MINUS_INF;
    end else if (qual_hits[6]) begin
      qual_next.rounding = ROUND_CHOPPED;
    end
    qual_next.inexact_en    = qual_hits[3];
    qual_next.completion_en = qual_hits[2];
    qual_next.underflow_en  = qual_hits[1];
    qual_next.overflow_en   = qual_hits[0];
  end

  // Address arithmetic
  wire logic [XLEN-1:0] disp_sign_extend =
    {{(XLEN-DISP_W){req_in.disp[DISP_W-1]}}, req_in.disp};
  wire logic [XLEN-1:0] va = req_in.base_value + disp_sign_extend;
  wire logic [XLEN-1:0] low_sum = va;
  wire logic [XLEN-1:0] high_sum = req_in.base_value +
    (disp_sign_extend << HIGH_SHIFT);

  // Operation decode
  wire logic is_addr_low  = req_in.op == OP_ADDRESS_COMPUTE_LOAD;
  wire logic is_addr_high = req_in.op == OP_ADDRESS_COMPUTE_HIGH_LOAD;
  wire logic is_quad      = req_in.op == OP_QUADWORD_LOAD;
  wire logic is_long      = req_in.op == OP_SIGNED_LONGWORD_LOAD;
  wire logic is_word      = req_in.op == OP_UNSIGNED_WORD_LOAD;
  wire logic is_byte      = req_in.op == OP_UNSIGNED_BYTE_LOAD;
  wire logic is_unaligned = req_in.op == OP_UNALIGNED_QUADWORD_LOAD;
  wire logic is_addr_op   = is_addr_low | is_addr_high;
  wire logic dest_zero    = req_in.dest_reg_field == ZERO_REG;
  wire logic is_plain_pf  = is_long & dest_zero;
  wire logic is_evict_pf  = is_quad & dest_zero;
  wire logic is_plain_a  = is_plain_pf | is_evict_pf;

  wire access_size_type req_size =
    is_byte ? SIZE_BYTE :
    is_word ? SIZE_WORD :
    is_long ? SIZE_LONG : SIZE_QUAD;
  wire logic [2:0] align_mask =
    is_byte ? ALIGN_BYTE :
    is_word ? ALIGN_WORD :
    is_long ? ALIGN_LONG : ALIGN_QUAD;
  wire logic [2:0] xor_bits =
    is_byte ? XOR_BYTE :
    is_word ? XOR_WORD :
    is_long ? XOR_LONG : XOR_QUAD;

  // Unaligned quadword loads clear the low bits, so never trap
  wire logic misaligned = ~is_unaligned &
    (|(va[2:0] & align_mask));
  // Without word and byte hardware these trap to software
  wire logic emulate = (is_word | is_byte) & ~HW_WORD_BYTE;

  // Byte address sent to memory, lanes flipped in big-endian mode
  wire logic [XLEN-1:0] aligned_va = {va[XLEN-1:3], 3'h0};
  wire logic [XLEN-1:0] adj_addr = is_unaligned ? aligned_va :
    {va[XLEN-1:3],
     va[2:0] ^ (big_endian_reg ? xor_bits : XOR_QUAD)};

  // Request handshake
  assign req_ready_out = ce_in & (st_reg == ST_IDLE);
  wire logic take = req_valid_in & req_ready_out;
  assign mem_req_valid_out = st_reg == ST_ISSUE;
  wire logic issued = ce_in & mem_req_valid_out & mem_req_ready_in;
  wire logic rsp_take = ce_in & (st_reg == ST_WAIT) & mem_rsp_valid_in;

  // Memory data placed rightmost and extended per size
  logic [XLEN-1:0] ext_data;
  always_comb begin
    case (pend_size_reg)
      SIZE_QUAD: ext_data = mem_rsp_in.data;
      SIZE_LONG: ext_data = {{(XLEN-32){mem_rsp_in.data[31]}},
                             mem_rsp_in.data[31:0]};
      SIZE_WORD: ext_data = {{(XLEN-16){1'b0}},
                             mem_rsp_in.data[15:0]};
      default:   ext_data = {{(XLEN-8){1'b0}},
                             mem_rsp_in.data[7:0]};
    endcase
  end

  // Only the listed fault classes pass through; others map to read fault
  wire fault_type rsp_fault =
    (mem_rsp_in.fault == FAULT_ALIGNMENT ||
     mem_rsp_in.fault == FAULT_EMULATE) ? FAULT_ON_READ :
    mem_rsp_in.fault;

  // Result of an accepted request, formed in the accept cycle or on the memory reply
  wire logic early_fault = ~is_addr_op & (misaligned | emulate);
  wire fault_type early_code = misaligned ? FAULT_ALIGNMENT : FAULT_EMULATE;
  wire logic early_wb   = take & is_addr_op;
  // Misaligned prefetches are dropped: no access, no fault
  wire logic early_err  = take & early_fault & ~is_plain_a;
  wire logic go_memory  = take & ~is_addr_op & ~early_fault;
  wire logic late_wb    = rsp_take & mem_rsp_in.fault == FAULT_NONE;
  wire logic late_err   = rsp_take & mem_rsp_in.fault != FAULT_NONE;

  result_type result_next;
  always_comb begin
    result_next = result_reg;
    if (early_wb) begin
      result_next.dest_reg_field = req_in.dest_reg_field;
      result_next.data  = is_addr_high ? high_sum : low_sum;
      result_next.fault = FAULT_NONE;
      result_next.fault_va = '0;
    end else if (early_err) begin
      result_next.dest_reg_field = req_in.dest_reg_field;
      result_next.data  = '0;
      result_next.fault = early_code;
      result_next.fault_va = va;
    end else if (late_wb) begin
      result_next.dest_reg_field = pend_dest_reg;
      result_next.data  = ext_data;
      result_next.fault = FAULT_NONE;
      result_next.fault_va = '0;
    end else if (late_err) begin
      result_next.dest_reg_field = pend_dest_reg;
      result_next.data  = '0;
      result_next.fault = rsp_fault;
      result_next.fault_va = pend_va_reg;
    end
  end

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (go_memory) begin
          st_next = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (issued) begin
          // Prefetches get no reply, so skip the wait
          st_next = pend_plain_a_reg ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (rsp_take) begin
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // Memory request: whole byte address and size, reads only
  wire mem_req_type mem_req_next = '{adj_addr, req_size,
    is_plain_pf, is_evict_pf};

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= ST_IDLE;
      mem_req_reg <= '0;
      pend_dest_reg <= '0;
      pend_va_reg <= '0;
      pend_size_reg <= SIZE_QUAD;
      pend_plain_a_reg <= 1'b0;
    end else if (ce_in) begin
      st_reg <= st_next;
      if (go_memory) begin
        mem_req_reg <= mem_req_next;
        pend_dest_reg <= req_in.dest_reg_field;
        // Fault address is taken before lane inversion
        pend_va_reg <= is_unaligned ? aligned_va : va;
        pend_size_reg <= req_size;
        pend_plain_a_reg <= is_plain_a;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_reg <= '0;
      wb_valid_reg <= 1'b0;
      fault_valid_reg <= 1'b0;
      qual_reg <= QUAL_DEFAULT;
    end else if (ce_in) begin
      result_reg <= result_next;
      wb_valid_reg <= early_wb | late_wb;
      fault_valid_reg <= early_err | late_err;
      qual_reg <= qual_next;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_fault_reg <= FAULT_NONE;
      last_fault_va_reg <= '0;
    end else if (ce_in && (early_err || late_err)) begin
      last_fault_reg <= result_next.fault;
      last_fault_va_reg <= result_next.fault_va;
    end
  end

  // Pulses last one cycle; the result word holds until the next
  assign mem_req_out     = mem_req_reg;
  assign result_out      = result_reg;
  assign wb_valid_out    = wb_valid_reg;
  assign fault_valid_out = fault_valid_reg;
  assign qual_out        = qual_reg;

  // Register bus slave, zero wait states, always OKAY
  wire logic bus_phase = ce_in & hsel_in & htrans_in[1] & hready_in;
  wire logic [31:0] feature_value =
    {31'h0, ~HW_WORD_BYTE} << FEATURE_WORD_BYTE_BIT;
  // Last fault code and address stay until the next fault
  wire logic [31:0] status_value =
    ({29'h0, last_fault_reg}) |
    ({31'h0, st_reg != ST_IDLE} << STATUS_BUSY_BIT);
  wire logic [7:0] rd_addr = haddr_in[7:0];
  wire logic addr_hit = haddr_in[31:8] == 24'h000000;
  wire logic [31:0] rd_value =
    !addr_hit ? 32'h00000000 :
    rd_addr == CTRL_OFFSET ?
      {31'h0, big_endian_reg} << CTRL_BIG_ENDIAN_BIT :
    rd_addr == FEATURE_OFFSET ? feature_value :
    rd_addr == STATUS_OFFSET ? status_value :
    rd_addr == FAULT_VA_LO_OFFSET ? last_fault_va_reg[31:0] :
    rd_addr == FAULT_VA_HI_OFFSET ? last_fault_va_reg[63:32] :
    32'h00000000;
  // Write data arrives one cycle after its address phase
  wire logic ctrl_wr = bus_wr_reg & ce_in & bus_addr_reg == CTRL_OFFSET;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= '0;
      hrdata_reg <= '0;
      big_endian_reg <= CTRL_BIG_ENDIAN_RST;
    end else if (ce_in) begin
      bus_wr_reg <= bus_phase & hwrite_in & addr_hit;
      bus_addr_reg <= rd_addr;
      if (bus_phase && !hwrite_in) begin
        hrdata_reg <= rd_value;
      end
      if (ctrl_wr) begin
        big_endian_reg <= hwdata_in[CTRL_BIG_ENDIAN_BIT];
      end
    end
  end

  // The bus stalls only while the clock enable is low
  assign hreadyout_out = ce_in;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_reg;

endmodule

// ---- testbench/load_unit_checker.sv ----
`timescale 1ns/1ns
module load_unit_checker
  import load_unit_pkg::*;
#(
  parameter int QUAL_CHARS   = 4,
  parameter bit HW_WORD_BYTE = 1'b1
) (
  input wire logic                         ref_clk_in,
  input wire logic                         rst_in,
  input wire logic                         ce_in,
  input wire logic [QUAL_CHARS*CHAR_W-1:0] qual_chars_in,
  input wire qualifier_type                qual_out,
  input wire logic                         req_valid_in,
  input wire load_req_type                 req_in,
  input wire logic                         req_ready_out,
  input wire logic                         mem_req_valid_out,
  input wire mem_req_type                  mem_req_out,
  input wire logic                         wb_valid_out,
  input wire logic                         fault_valid_out,
  input wire result_type                   result_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  wire load_op_type op   = req_in.op;
  wire logic        take = req_valid_in && req_ready_out && ce_in;
  wire logic [63:0] lo   = req_in.base_value
                         + {{48{req_in.disp[15]}}, req_in.disp};
  wire logic [63:0] hi   = req_in.base_value
                         + {{32{req_in.disp[15]}}, req_in.disp, 16'h0000};
  wire logic [63:0] clr  = {lo[63:3], 3'h0};
  wire logic [2:0]  am   = op == OP_QUADWORD_LOAD ? 3'h7
                         : op == OP_SIGNED_LONGWORD_LOAD ? 3'h3
                         : op == OP_UNSIGNED_WORD_LOAD ? 3'h1 : 3'h0;
  wire logic        pf   = req_in.dest_reg_field == ZERO_REG && am[1];
  wire logic        sz   = am != 3'h0 || op == OP_UNSIGNED_BYTE_LOAD;
  wire logic        bad  = sz && |(lo[2:0] & am) && !pf
                         && (HW_WORD_BYTE || am[1]);

  a_qual_default: assert property (
    ce_in && qual_chars_in == '0 |=> qual_out == QUAL_DEFAULT)
    else $error("qualifier default wrong");
  a_addr_low: assert property (
    take && op == OP_ADDRESS_COMPUTE_LOAD
    |=> wb_valid_out && result_out.data == $past(lo))
    else $error("address load sum wrong");
  a_addr_high: assert property (
    take && op == OP_ADDRESS_COMPUTE_HIGH_LOAD
    |=> wb_valid_out && result_out.data == $past(hi))
    else $error("high address load sum wrong");
  a_addr_nofault: assert property (
    take && (op == OP_ADDRESS_COMPUTE_LOAD
    || op == OP_ADDRESS_COMPUTE_HIGH_LOAD)
    |=> wb_valid_out && !fault_valid_out)
    else $error("address load faulted");
  a_align_fault: assert property (
    take && bad |=> fault_valid_out && result_out.fault == FAULT_ALIGNMENT
    && result_out.fault_va == $past(lo))
    else $error("misaligned load not faulted");
  a_unal_clear: assert property (
    take && op == OP_UNALIGNED_QUADWORD_LOAD |=> !fault_valid_out
    && mem_req_valid_out && mem_req_out.endian_adjusted_addr == $past(clr))
    else $error("unaligned quadword address wrong");
  a_evict_pf: assert property (
    take && op == OP_QUADWORD_LOAD && pf && lo[2:0] == 3'h0
    |=> mem_req_valid_out && mem_req_out.evict_next_plain_a)
    else $error("quadword plain_a not issued");
  a_long_pf: assert property (
    take && op == OP_SIGNED_LONGWORD_LOAD && pf && lo[1:0] == 2'h0
    |=> mem_req_valid_out && mem_req_out.plain_a)
    else $error("longword plain_a not issued");
  a_pulse_excl: assert property (
    !(wb_valid_out && fault_valid_out))
    else $error("write and fault together");

  c_wb: cover property (wb_valid_out);
  c_align: cover property (fault_valid_out
    && result_out.fault == FAULT_ALIGNMENT);
  c_evict: cover property (mem_req_valid_out
    && mem_req_out.evict_next_plain_a);
endmodule

bind integer_load_unit load_unit_checker #(
  .QUAL_CHARS  (QUAL_CHARS),
  .HW_WORD_BYTE(HW_WORD_BYTE)
) u_load_unit_checker (
  .ref_clk_in, .rst_in, .ce_in, .qual_chars_in, .qual_out,
  .req_valid_in, .req_in, .req_ready_out, .mem_req_valid_out,
  .mem_req_out, .wb_valid_out, .fault_valid_out, .result_out
);

// ---- testbench/mem_model.sv ----
`timescale 1ns/1ns
module mem_model
  import load_unit_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        mem_req_valid_in,
  input  wire mem_req_type mem_req_in,
  input  wire fault_type   fault_in,
  input  wire logic [1:0]  delay_in,
  output logic             mem_req_ready_out,
  output logic             mem_rsp_valid_out,
  output mem_rsp_type      mem_rsp_out
);
  logic [1:0]  cnt_reg;
  logic        busy_reg;
  mem_req_type held_reg;

  function automatic logic [63:0] pat(input logic [63:0] a);
    return {a[31:0] ^ 32'h5A3C96E1, ~a[31:0] ^ a[63:32]};
  endfunction

  // Idle data lines toggle so stale data is never mistaken for a reply
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 2'h0;
      busy_reg <= 1'b0;
      held_reg <= '0;
      mem_req_ready_out <= 1'b0;
      mem_rsp_valid_out <= 1'b0;
      mem_rsp_out <= '0;
    end else begin
      mem_rsp_valid_out <= 1'b0;
      mem_rsp_out.data <= ~mem_rsp_out.data;
      if (busy_reg) begin
        cnt_reg <= cnt_reg - 2'h1;
        if (cnt_reg == 2'h0) begin
          busy_reg <= 1'b0;
          mem_rsp_valid_out <= 1'b1;
          mem_rsp_out <= '{pat(held_reg.endian_adjusted_addr), fault_in};
        end
      end else if (mem_req_valid_in && mem_req_ready_out) begin
        mem_req_ready_out <= 1'b0;
        held_reg <= mem_req_in;
        busy_reg <= !(mem_req_in.plain_a || mem_req_in.evict_next_plain_a);
        cnt_reg <= delay_in;
      end else if (!mem_req_valid_in) begin
        cnt_reg <= delay_in;
      end else begin
        mem_req_ready_out <= cnt_reg == 2'h0;
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
endmodule

// ---- testbench/tb_integer_load_unit.sv ----
`timescale 1ns/1ns
module tb_integer_load_unit
  import load_unit_pkg::*;
;
  logic          clk, rst, hsel, hwrite, hrdy, hresp, req_v, req_rdy;
  logic          mv, mr, rv, wb, fv;
  logic [1:0]    htrans, dly;
  logic [31:0]   haddr, hwdata, hrdata, qchars, rd;
  qualifier_type qual, eq;
  load_req_type  req;
  mem_req_type   mreq;
  mem_rsp_type   mrsp;
  result_type    res;
  fault_type     finj, lf;
  logic [63:0]   lfva;
  int            num_errors, samples_checked, seed, k, be;
  localparam logic [55:0] QL = {CHAR_V, CHAR_U, CHAR_S, CHAR_I, CHAR_M,
                                CHAR_D, CHAR_C};

  integer_load_unit u_integer_load_unit (
    .ref_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
    .qual_chars_in(qchars), .qual_out(qual), .req_valid_in(req_v),
    .req_in(req), .req_ready_out(req_rdy), .mem_req_valid_out(mv),
    .mem_req_out(mreq), .mem_req_ready_in(mr), .mem_rsp_valid_in(rv),
    .mem_rsp_in(mrsp), .wb_valid_out(wb), .fault_valid_out(fv),
    .result_out(res));
  mem_model u_mem_model (
    .ref_clk_in(clk), .rst_in(rst), .mem_req_valid_in(mv),
    .mem_req_in(mreq), .fault_in(finj), .delay_in(dly),
    .mem_req_ready_out(mr), .mem_rsp_valid_out(rv), .mem_rsp_out(mrsp));

  task automatic chk(input logic [63:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task report_and_stop();
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (!hrdy);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hrdy);
    r = hrdata;
    chk(hresp, 1'b0);
  endtask

  task automatic do_load();
    load_req_type q;
    logic [63:0]  va, adj, d, ex, fva;
    logic [2:0]   am, xm;
    logic         pf, seen;
    fault_type    f, ef;
    int           kind, ek, r;
    q.op = load_op_type'($unsigned($random(seed)) % 7);
    q.dest_reg_field = ($random(seed) & 3) ? $random(seed) : 5'h1F;
    q.base_value = {$random(seed), $random(seed)};
    q.disp = $random(seed);
    if ($random(seed) & 1) begin
      q.base_value[2:0] = 3'h0;
      q.disp[2:0] = 3'h0;
    end
    r = $unsigned($random(seed)) % 8;
    f = r == 5 ? FAULT_ACCESS_VIOLATION : r == 6 ? FAULT_ON_READ
      : r == 7 ? FAULT_TRANSLATION_NOT_VALID : FAULT_NONE;
    va = q.base_value + {{48{q.disp[15]}}, q.disp};
    {am, xm} = 6'h00;
    case (q.op)
      OP_QUADWORD_LOAD: am = 3'h7;
      OP_SIGNED_LONGWORD_LOAD: {am, xm} = 6'h1C;
      OP_UNSIGNED_WORD_LOAD: {am, xm} = 6'h0E;
      OP_UNSIGNED_BYTE_LOAD: xm = 3'h7;
      default: ;
    endcase
    adj = be ? va ^ {61'h0, xm} : va;
    if (q.op == OP_UNALIGNED_QUADWORD_LOAD) adj = {va[63:3], 3'h0};
    d = u_mem_model.pat(adj);
    ex = d;
    if (am == 3'h3) ex = {{32{d[31]}}, d[31:0]};
    if (am == 3'h1) ex = {48'h0, d[15:0]};
    if (xm == 3'h7) ex = {56'h0, d[7:0]};
    pf = q.dest_reg_field == 5'h1F && am[1];
    ef = f;
    fva = q.op == OP_UNALIGNED_QUADWORD_LOAD ? adj : va;
    ek = f == FAULT_NONE ? 1 : 2;
    if (q.op == OP_ADDRESS_COMPUTE_LOAD) {ek, ex} = {32'd1, va};
    else if (q.op == OP_ADDRESS_COMPUTE_HIGH_LOAD) begin
      ek = 1;
      ex = q.base_value + {{32{q.disp[15]}}, q.disp, 16'h0};
    end else if ((va[2:0] & am) != 3'h0 || (xm == 3'h6 && va[0])) begin
      ek = pf ? 0 : 2;
      ef = FAULT_ALIGNMENT;
      fva = va;
    end else if (pf) ek = 0;
    @(posedge clk);
    finj <= f;
    dly <= $random(seed);
    req <= q;
    req_v <= 1'b1;
    do @(negedge clk); while (!req_rdy);
    @(posedge clk);
    req_v <= 1'b0;
    kind = 0;
    seen = 0;
    repeat (30) begin
      @(negedge clk);
      if (mv && !seen) chk(mreq.endian_adjusted_addr, adj);
      seen |= mv;
      if (kind == 0 && (wb || fv)) kind = wb ? 1 : 2;
    end
    chk(kind, ek);
    if (ek == 1) chk(res.data, ex);
    if (ek == 1) chk(res.dest_reg_field, q.dest_reg_field);
    if (ek == 2) chk(res.fault, ef);
    if (ek == 2) chk(res.fault_va, fva);
    if (ek == 2) begin
      lf = ef;
      lfva = fva;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'h776D49E4;
    {hsel, hwrite, htrans, haddr, hwdata, qchars, req_v} = '0;
    rst = 1'b1;
    req = '0;
    finj = FAULT_NONE;
    lf = FAULT_NONE;
    lfva = 64'h0;
    dly = 2'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(qual, QUAL_DEFAULT);
    for (k = 0; k < 7; k++) begin
      qchars <= {24'h0, QL[8*k+:8]};
      eq = QUAL_DEFAULT;
      case (k)
        0: eq.rounding = ROUND_CHOPPED;
        1: eq.rounding = ROUND_DYNAMIC;
        2: eq.rounding = ROUND_MINUS_INF;
        3: eq.inexact_en = 1'b1;
        4: eq.completion_en = 1'b1;
        5: eq.underflow_en = 1'b1;
        default: eq.overflow_en = 1'b1;
      endcase
      repeat (2) @(posedge clk);
      chk(qual, eq);
    end
    qchars <= {CHAR_I, CHAR_S, CHAR_U, CHAR_C};
    eq = QUAL_DEFAULT;
    eq.rounding = ROUND_CHOPPED;
    eq.inexact_en = 1'b1;
    eq.completion_en = 1'b1;
    eq.underflow_en = 1'b1;
    repeat (2) @(posedge clk);
    chk(qual, eq);
    qchars <= 32'h0;
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk(rd, 64'h0);
    ahb(1'b0, 32'h40, 32'h0, rd);
    chk(rd, 64'h0);
    for (be = 0; be < 2; be++) begin
      ahb(1'b1, 32'h0, be, rd);
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk(rd, be);
      repeat (150) do_load();
    end
    ahb(1'b0, {24'h0, STATUS_OFFSET}, 32'h0, rd);
    chk(rd, {61'h0, lf});
    ahb(1'b0, {24'h0, FAULT_VA_LO_OFFSET}, 32'h0, rd);
    chk(rd, lfva[31:0]);
    ahb(1'b0, {24'h0, FAULT_VA_HI_OFFSET}, 32'h0, rd);
    chk(rd, lfva[63:32]);
    report_and_stop();
  end
endmodule
